// File: verilog/acsq_pkg.sv
/*
  acsq_pkg: constants and types of the list-based converter sequencer.
  assumes a byte-wide register port and a 24-bit system address space.
*/
package acsq_pkg;

  // register offsets on the byte-wide port
  localparam logic [7:0] ACSQ_CTRL_ADR = 8'h00;
  localparam logic [7:0] ACSQ_SMPT_ADR = 8'h01;
  localparam logic [7:0] ACSQ_TRIG_ADR = 8'h02;
  localparam logic [7:0] ACSQ_STAT_ADR = 8'h03;
  localparam logic [7:0] ACSQ_CIDX_ADR = 8'h04;
  localparam logic [7:0] ACSQ_RIDX_ADR = 8'h05;
  localparam logic [7:0] ACSQ_CMD0_ADR = 8'h08; // four bytes, lsb first
  localparam logic [7:0] ACSQ_OFF0_ADR = 8'h24;
  localparam logic [7:0] ACSQ_OFF1_ADR = 8'h25;

  // control register fields
  localparam int CTL_EN   = 0;
  localparam int CTL_SMOD = 1;
  localparam int CTL_CBM  = 2;
  localparam int CTL_RBM  = 3;
  localparam int CTL_JSEL = 4;
  localparam int CTL_RES  = 5; // two bits
  // trigger register fields
  localparam int TRG_GO    = 0;
  localparam int TRG_CSWAP = 1;

  // reset values
  localparam logic [6:0] ZERO_OFF = 7'h00;

  // command word fields and types
  localparam int         CMD_TYPE_LSB = 30;
  localparam int         CMD_CH_LSB   = 0;
  localparam logic [1:0] CT_NORMAL    = 2'h0;
  localparam logic [1:0] CT_END_SEQ   = 2'h1;
  localparam logic [5:0] CMD_LAST     = 6'h3f; // 64 entries per list

  // entry sizes as address shifts: 32-bit commands, 16-bit results
  localparam int CMD_SHIFT = 2;
  localparam int RES_SHIFT = 1;

  // timing in converter clock cycles
  localparam logic [4:0] PUMP_CYC     = 5'h02;
  localparam logic [4:0] BUFA_CYC     = 5'h02;
  localparam logic [4:0] SMP_MIN_CYC  = 5'h04;
  localparam logic [4:0] SMP_MAX_CODE = 5'h14;
  localparam logic [4:0] SAR_WAIT_CYC = 5'h03; // dac settle + comparator sync
  localparam logic [4:0] RES_BITS     = 5'h10;

  typedef enum logic [6:0] {
    ACSQ_IDLE  = 7'h01,
    ACSQ_FETCH = 7'h02,
    ACSQ_PUMP  = 7'h04,
    ACSQ_BUFS  = 7'h08,
    ACSQ_FINAL = 7'h10,
    ACSQ_CONV  = 7'h20,
    ACSQ_STORE = 7'h40
  } acsq_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } acsq_res_s;

  typedef struct packed {
    acsq_state_e st;
    logic [4:0]  cnt;
    logic [3:0]  bitn;
    logic [7:0]  ctl;
    logic [4:0]  smp;
    logic [6:0]  alt_off;
    logic        cmd_sel;
    logic        res_sel;
    logic [5:0]  cidx;
    logic [6:0]  ridx;
    logic [31:0] fetch_w;
    logic [31:0] act;
    logic [11:0] acc;
    logic [11:0] dac;
    logic        pump;
    logic        bamp;
    logic        direct;
    logic        hold;
    logic        freq;
    logic [23:0] faddr;
    logic [7:0]  rdata;
    logic        b0v;
    acsq_res_s   b0;
    logic        b1v;
    acsq_res_s   b1;
    logic        cmp_m;
    logic        cmp_s;
  } acsq_state_s;

  localparam acsq_state_s ACSQ_STATE_RST = '{st: ACSQ_IDLE, default: '0};

endpackage : acsq_pkg

// File: verilog/acsq_top.sv
/*
  acsq_top: list-based sequencer of a successive-approximation converter.
  assumes memory and register logic on i_clk; only i_cmp is asynchronous.
*/
// How it works
// - the first list offset always reads zero; writes leave it unchanged.
// - the alternate offset is written only when disabled or in special mode.
// - offsets count entries: 16-bit results, 32-bit commands.
// - first lists use the zero offset, second lists the alternate one.
// - sampling runs two cycles through the buffer amplifier, then direct.
// - two pump cycles come right before every sample phase.
// - the input stays disconnected during hold and conversion.
// - resolution is eight, ten or twelve bits by software choice.
// - each result is found by binary search, msb first.
// - a command list holds at most 64 commands; no fetch beyond it.
// - one trigger runs the whole sequence without further triggers.
// - an end-of-sequence or end-of-list type stops the sequence.
// - a list may hold one up to 64 sequences.
// - single or double buffering is chosen per list.
// - fetched commands are double-buffered; the active one is readable.
// - fetch address is base plus offset plus index, scaled by entry size.
// - results are unsigned 16-bit, justified as chosen, unused bits zero.
`timescale 1ns/1ps
`default_nettype none

module acsq_top
  import acsq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [23:0] i_cmd_base,
  input  wire logic [23:0] i_res_base,
  output logic             o_fetch_req,
  output logic      [23:0] o_fetch_addr,
  input  wire logic        i_fetch_valid,
  input  wire logic [31:0] i_fetch_data,
  output logic             o_res_valid,
  output logic      [23:0] o_res_addr,
  output logic      [15:0] o_res_data,
  input  wire logic        i_res_ready,
  output logic      [5:0]  o_channel,
  output logic             o_pump,
  output logic             o_buf_amp,
  output logic             o_direct,
  output logic             o_hold,
  output logic      [11:0] o_dac_code,
  input  wire logic        i_cmp
);

  acsq_state_s q;
  acsq_state_s d;
  logic [3:0]  nbits;
  logic [4:0]  smp_cyc;
  logic [4:0]  jshift;
  logic [6:0]  res_off;
  logic [7:0]  res_ofs;
  logic [1:0]  ctype;
  logic [11:0] acc_new;
  logic        pop;
  logic        push;
  logic        go;
  logic        cswap;
  logic        last_cmd;
  acsq_res_s   ent;

  // command fetch address for a given list index
  function automatic logic [23:0] cmd_addr(input logic [23:0] base,
                                           input logic        sel,
                                           input logic [6:0]  alt,
                                           input logic [5:0]  idx);
    logic [7:0] ofs;
    ofs = {1'b0, (sel ? alt : ZERO_OFF)} + {2'b00, idx};
    return base + ({16'h0000, ofs} << CMD_SHIFT);
  endfunction : cmd_addr

  // decoded configuration and result entry
  always_comb begin : decode
    unique case (q.ctl[CTL_RES +: 2])
      2'h0:    nbits = 4'h8;
      2'h1:    nbits = 4'ha;
      default: nbits = 4'hc;
    endcase
    smp_cyc  = (q.smp > SMP_MAX_CODE) ? (SMP_MAX_CODE + SMP_MIN_CYC)
                                      : (q.smp + SMP_MIN_CYC);
    jshift   = RES_BITS - {1'b0, nbits};
    res_off  = q.res_sel ? q.alt_off : ZERO_OFF;
    res_ofs  = {1'b0, res_off} + {1'b0, q.ridx};
    ctype    = q.act[CMD_TYPE_LSB +: 2];
    last_cmd = (q.cidx == CMD_LAST);
    acc_new  = q.cmp_s ? q.dac : q.acc;
    ent.addr = i_res_base + ({16'h0000, res_ofs} << RES_SHIFT);
    if (q.ctl[CTL_JSEL]) begin
      ent.data = {4'h0, q.acc};
    end else begin
      ent.data = 16'({4'h0, q.acc} << jshift);
    end
  end

  // next-state logic: register port, sequencer and result buffer
  always_comb begin : next
    d      = q;
    go     = 1'b0;
    cswap  = 1'b0;
    push   = 1'b0;
    pop    = q.b0v && i_res_ready;
    d.cmp_m = i_cmp;
    d.cmp_s = q.cmp_m;

    // register writes
    if (i_wr) begin
      case (i_addr)
        ACSQ_CTRL_ADR: d.ctl = i_wdata;
        ACSQ_SMPT_ADR: d.smp = i_wdata[4:0];
        ACSQ_TRIG_ADR: begin
          go    = i_wdata[TRG_GO];
          cswap = i_wdata[TRG_CSWAP];
        end
        ACSQ_OFF1_ADR: begin
          if (!q.ctl[CTL_EN] || q.ctl[CTL_SMOD]) begin
            d.alt_off = i_wdata[6:0];
          end
        end
        default: ; // the zero offset ignores writes
      endcase
    end

    // register reads, data valid in the next cycle only
    d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ACSQ_CTRL_ADR: d.rdata = q.ctl;
        ACSQ_SMPT_ADR: d.rdata = {3'h0, q.smp};
        ACSQ_STAT_ADR: d.rdata = {4'h0, q.res_sel, q.cmd_sel, q.b1v,
                                  (q.st != ACSQ_IDLE)};
        ACSQ_CIDX_ADR: d.rdata = {2'h0, q.cidx};
        ACSQ_RIDX_ADR: d.rdata = {1'b0, q.ridx};
        ACSQ_OFF0_ADR: d.rdata = {1'b0, ZERO_OFF};
        ACSQ_OFF1_ADR: d.rdata = {1'b0, q.alt_off};
        default: begin
          if (i_addr[7:2] == ACSQ_CMD0_ADR[7:2]) begin
            d.rdata = q.act[{i_addr[1:0], 3'h0} +: 8];
          end
        end
      endcase
    end

    // sequencer
    unique case (q.st)
      ACSQ_IDLE: begin
        if (cswap && q.ctl[CTL_CBM]) begin
          d.cmd_sel = ~q.cmd_sel;
        end
        if (go && q.ctl[CTL_EN]) begin
          d.st    = ACSQ_FETCH;
          d.freq  = 1'b1;
          d.faddr = cmd_addr(i_cmd_base, d.cmd_sel, q.alt_off, q.cidx);
        end
      end
      ACSQ_FETCH: begin
        if (i_fetch_valid) begin
          d.freq    = 1'b0;
          d.fetch_w = i_fetch_data;
          d.st      = ACSQ_PUMP;
          d.cnt     = PUMP_CYC - 5'h01;
        end
      end
      ACSQ_PUMP: begin
        if (q.cnt == PUMP_CYC - 5'h01) begin
          d.act = q.fetch_w;
        end
        if (q.cnt == 5'h00) begin
          d.st  = ACSQ_BUFS;
          d.cnt = BUFA_CYC - 5'h01;
        end else begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      ACSQ_BUFS: begin
        if (q.cnt == 5'h00) begin
          d.st  = ACSQ_FINAL;
          d.cnt = smp_cyc - BUFA_CYC - 5'h01;
        end else begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      ACSQ_FINAL: begin
        if (q.cnt == 5'h00) begin
          d.st   = ACSQ_CONV;
          d.bitn = nbits - 4'h1;
          d.acc  = 12'h000;
          d.dac  = 12'h001 << (nbits - 4'h1);
          d.cnt  = SAR_WAIT_CYC - 5'h01;
        end else begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      ACSQ_CONV: begin
        if (q.cnt != 5'h00) begin
          d.cnt = q.cnt - 5'h01;
        end else begin
          d.acc = acc_new;
          if (q.bitn == 4'h0) begin
            d.st = ACSQ_STORE;
          end else begin
            d.bitn = q.bitn - 4'h1;
            d.dac  = acc_new | (12'h001 << (q.bitn - 4'h1));
            d.cnt  = SAR_WAIT_CYC - 5'h01;
          end
        end
      end
      ACSQ_STORE: begin
        if (!q.b1v) begin
          push   = 1'b1;
          d.ridx = q.ridx + 7'h01;
          if (ctype == CT_NORMAL && !last_cmd) begin
            d.cidx  = q.cidx + 6'h01;
            d.st    = ACSQ_FETCH;
            d.freq  = 1'b1;
            d.faddr = cmd_addr(i_cmd_base, q.cmd_sel, q.alt_off, d.cidx);
          end else if (ctype == CT_END_SEQ && !last_cmd) begin
            d.cidx = q.cidx + 6'h01;
            d.st   = ACSQ_IDLE;
          end else begin
            d.cidx = 6'h00;
            d.ridx = 7'h00;
            d.st   = ACSQ_IDLE;
            if (q.ctl[CTL_RBM]) begin
              d.res_sel = ~q.res_sel;
            end
          end
        end
      end
      default: d.st = ACSQ_IDLE;
    endcase

    // disabling aborts any conversion and rewinds both lists
    if (!d.ctl[CTL_EN]) begin
      d.st   = ACSQ_IDLE;
      d.freq = 1'b0;
      d.cidx = 6'h00;
      d.ridx = 7'h00;
    end
    if (!d.ctl[CTL_CBM]) begin
      d.cmd_sel = 1'b0;
    end
    if (!d.ctl[CTL_RBM]) begin
      d.res_sel = 1'b0;
    end

    // analog switches follow the next state
    d.pump   = (d.st == ACSQ_PUMP);
    d.bamp   = (d.st == ACSQ_BUFS);
    d.direct = (d.st == ACSQ_FINAL);
    d.hold   = (d.st == ACSQ_CONV);

    // two-entry result buffer: b0 is the output stage
    if (pop) begin
      d.b0v = q.b1v;
      d.b0  = q.b1;
      d.b1v = 1'b0;
    end
    if (push) begin
      if (!d.b0v) begin
        d.b0v = 1'b1;
        d.b0  = ent;
      end else begin
        d.b1v = 1'b1;
        d.b1  = ent;
      end
    end
  end

  // all state in one register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_n) begin : regs
    if (!i_rst_n) begin
      q <= ACSQ_STATE_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign o_rdata      = q.rdata;
  assign o_fetch_req  = q.freq;
  assign o_fetch_addr = q.faddr;
  assign o_res_valid  = q.b0v;
  assign o_res_addr   = q.b0.addr;
  assign o_res_data   = q.b0.data;
  assign o_channel    = q.act[CMD_CH_LSB +: 6];
  assign o_pump       = q.pump;
  assign o_buf_amp    = q.bamp;
  assign o_direct     = q.direct;
  assign o_hold       = q.hold;
  assign o_dac_code   = q.dac;

  // checks on the sequencer
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ZERO_OFF: assert property (
    i_ce && i_rd && i_addr == ACSQ_OFF0_ADR |=> o_rdata == 8'h00)
    else $error("zero offset read not zero");

  AST_ALT_LOCK: assert property (
    i_ce && i_wr && i_addr == ACSQ_OFF1_ADR && q.ctl[CTL_EN]
    && !q.ctl[CTL_SMOD] |=> $stable(q.alt_off))
    else $error("alternate offset written while locked");

  AST_FETCH_ADDR: assert property (
    $rose(o_fetch_req) && $stable(i_cmd_base) |->
    o_fetch_addr == i_cmd_base + ({16'h0000, ({1'b0,
    (q.cmd_sel ? q.alt_off : ZERO_OFF)} + {2'b00, q.cidx})} << 2))
    else $error("fetch address wrong");

  AST_PUMP_LEN: assert property (
    $rose(o_pump) ##0 i_ce ##1 i_ce |=> o_buf_amp && !o_pump)
    else $error("pump phase not two cycles");

  AST_BUF_LEN: assert property (
    $rose(o_buf_amp) ##0 i_ce ##1 i_ce |=> o_direct && !o_buf_amp)
    else $error("buffer phase not two cycles");

  AST_HOLD_OPEN: assert property (
    o_hold |-> !(o_buf_amp || o_direct || o_pump))
    else $error("input connected during hold");

  AST_MSB_FIRST: assert property (
    $rose(o_hold) |-> o_dac_code == (12'h001 << (nbits - 4'h1)))
    else $error("conversion does not start at msb");

  AST_SEQ_STOP: assert property (
    i_ce && q.st == ACSQ_STORE && !q.b1v && ctype != CT_NORMAL
    |=> q.st == ACSQ_IDLE)
    else $error("sequence did not stop");

  AST_LIST_END: assert property (
    i_ce && q.st == ACSQ_STORE && !q.b1v && last_cmd |=> q.cidx == 6'h00)
    else $error("command index passed list end");

  AST_JUSTIFY: assert property (
    push |-> (q.ctl[CTL_JSEL] ? (ent.data >> nbits)
                              : 16'(ent.data << nbits)) == 16'h0000)
    else $error("unused result bits not zero");

  AST_REFETCH: assert property (
    i_ce && q.st == ACSQ_STORE && !q.b1v && ctype == CT_NORMAL
    && !last_cmd |=> o_fetch_req || !q.ctl[CTL_EN])
    else $error("sequence stalled without a trigger");

  AST_RD_IDLE: assert property (
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside the read cycle");

  AST_NO_LOSS: assert property (
    i_ce && q.b1v && !i_res_ready |=> o_res_valid && $stable(o_res_data))
    else $error("buffered result lost");

  // scenarios the bench should reach
  COV_FULL: cover property (q.b0v && q.b1v && !i_res_ready);
  COV_BND:  cover property (q.st == ACSQ_STORE && last_cmd);
  COV_EOL:  cover property (q.st == ACSQ_STORE ##1 q.cidx == 6'h00);
  COV_12B:  cover property (push && nbits == 4'hc);
  COV_ALT:  cover property (i_wr && i_addr == ACSQ_OFF1_ADR ##1 q.alt_off != 7'h00);

endmodule : acsq_top

`default_nettype wire

// File: dv/acsq_mem_model.sv
/*
  acsq_mem_model: command memory, result sink and analog comparator.
  assumes the bench loads cmd[] and drives stall mode and random bits.
*/
`timescale 1ns/1ps
`default_nettype none

module acsq_mem_model
  import acsq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_stall,
  input  wire logic [1:0]  i_rnd,
  input  wire logic [1:0]  i_res,
  input  wire logic [23:0] i_base,
  input  wire logic        i_req,
  input  wire logic [23:0] i_addr,
  output logic             o_valid,
  output logic      [31:0] o_data,
  output logic             o_ready,
  input  wire logic [5:0]  i_ch,
  input  wire logic [11:0] i_dac,
  output logic             o_cmp
);
  logic [31:0] cmd [0:255];
  logic        hit;
  logic [3:0]  sh;

  // answer a pending fetch after a random wait; data scrambles otherwise
  assign hit = i_req && !o_valid && i_rnd[0];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_data  <= 32'h0;
    end else begin
      o_valid <= hit;
      o_data  <= (hit && i_addr[23:10] == i_base[23:10])
                 ? cmd[i_addr[9:2]] : ~o_data;
    end
  end

  // sink mode: 0 always ready, 1 random stalls, 2 never ready
  assign o_ready = (i_stall == 2'h0) || (i_stall == 2'h1 && i_rnd[1]);
  // input sits half a step above code {ch,~ch}; dac scaled to 12 bits
  assign sh    = (i_res == 2'h0) ? 4'h4 : (i_res == 2'h1) ? 4'h2 : 4'h0;
  assign o_cmp = {1'b0, i_ch, ~i_ch, 1'b1} > ({1'b0, i_dac, 1'b0} << sh);
endmodule : acsq_mem_model

`default_nettype wire

// File: dv/tb_list_based_adc_sequencer.sv
/*
  tb_list_based_adc_sequencer: self-checking bench of acsq_top.
  assumes acsq_pkg, acsq_top and acsq_mem_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_list_based_adc_sequencer
  import acsq_pkg::*;
;
  logic        clk, rst_n, wr, rd, fv, freq, rv, rr, cmp, ce;
  logic        pmp, bam, dir, hld, csel, rsel, jsel;
  logic [1:0]  stall, res;
  logic [3:0]  ph_q;
  logic [4:0]  smpc;
  logic [5:0]  ch, cidx;
  logic [6:0]  alt, ridx;
  logic [7:0]  adr, wd, rdat, run, dlen, v, e8;
  logic [11:0] dac;
  logic [15:0] rdt;
  logic [23:0] cbase, rbase, fadr, radr;
  logic [31:0] fdat, rnd, last;
  logic [39:0] exp_r;
  logic [39:0] q[$];
  int          n_fail, num_checks, i;

  acsq_top dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(adr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_cmd_base(cbase), .i_res_base(rbase), .o_fetch_req(freq),
    .o_fetch_addr(fadr), .i_fetch_valid(fv), .i_fetch_data(fdat),
    .o_res_valid(rv), .o_res_addr(radr), .o_res_data(rdt),
    .i_res_ready(rr), .o_channel(ch), .o_pump(pmp), .o_buf_amp(bam),
    .o_direct(dir), .o_hold(hld), .o_dac_code(dac), .i_cmp(cmp));

  acsq_mem_model mdl (
    .i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_rnd(rnd[1:0]),
    .i_res(res), .i_base(cbase), .i_req(freq), .i_addr(fadr),
    .o_valid(fv), .o_data(fdat), .o_ready(rr), .i_ch(ch), .i_dac(dac),
    .o_cmp(cmp));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // random stream for the memory model and stimulus
  always @(posedge clk) rnd <= xs(rnd);

  task automatic note(input logic ok, input logic [39:0] g, e);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : note

  task automatic chk_reg(input logic [7:0] g, e);
    note(g === e, {32'h0, g}, {32'h0, e});
  endtask : chk_reg

  task automatic chk_res(input logic [39:0] g, e);
    note(g === e, g, e);
  endtask : chk_res

  task automatic chk_ph(input logic [11:0] g, e);
    note(g === e, {28'h0, g}, {28'h0, e});
  endtask : chk_ph

  task automatic wrr(input logic [7:0] a, d);
    @(posedge clk);
    wr  <= 1'b1;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr

  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd  <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask : rdv

  task automatic rdr(input logic [7:0] a, e);
    logic [7:0] d;
    rdv(a, d);
    chk_reg(d, e);
  endtask : rdr

  // note the results of one sequence from the list contents
  task automatic plan();
    logic [31:0] w;
    logic [15:0] c;
    logic [3:0]  sh;
    logic        fin;
    sh  = (res == 2'h0) ? 4'h4 : (res == 2'h1) ? 4'h2 : 4'h0;
    fin = 1'b0;
    while (!fin) begin
      w = mdl.cmd[8'(csel ? alt : 7'h0) + 8'(cidx)];
      c = {4'h0, w[5:0], ~w[5:0]} >> sh;
      q.push_back({rbase + ((24'(rsel ? alt : 7'h0) + 24'(ridx)) << 1),
                   jsel ? c : c << (sh + 4'h4)});
      last = w;
      fin  = (w[31:30] != CT_NORMAL) || (cidx == CMD_LAST);
      if (w[31] || cidx == CMD_LAST) begin
        cidx = 6'h0;
        ridx = 7'h0;
        rsel = ~rsel;
      end else begin
        cidx++;
        ridx++;
      end
    end
  endtask : plan

  // wait for the noted results, then idle status and active command
  task automatic done();
    int k;
    for (k = 0; k < 5000 && q.size() != 0; k++) @(posedge clk);
    chk_reg(8'(q.size()), 8'h00);
    repeat (4) @(posedge clk);
    rdr(ACSQ_STAT_ADR, {4'h0, rsel, csel, 2'h0});
    for (k = 0; k < 4; k++) rdr(ACSQ_CMD0_ADR + 8'(k), last[8*k +: 8]);
  endtask : done

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // result order and content, and analog phase lengths
  always @(posedge clk) begin
    if (rv && rr) begin
      exp_r = (q.size() != 0) ? q.pop_front() : ~{radr, rdt};
      chk_res({radr, rdt}, exp_r);
    end
    dlen = ((smpc > 5'd20) ? 8'd24 : 8'(smpc) + 8'd4) - 8'd2;
    if ({hld, dir, bam, pmp} != ph_q) begin
      if (ph_q == 4'h1) chk_ph({hld, dir, bam, pmp, run}, 12'h202);
      if (ph_q == 4'h2) chk_ph({hld, dir, bam, pmp, run}, 12'h402);
      if (ph_q == 4'h4) chk_ph({hld, dir, bam, pmp, run}, {4'h8, dlen});
      run = 8'd1;
    end else begin
      run = run + 8'd1;
    end
    ph_q = {hld, dir, bam, pmp};
  end

  // watchdog sized well beyond the expected run
  initial begin
    #(40000 * 25);
    n_fail++;
    conclude();
  end

  // main sequence
  initial begin
    {rst_n, wr, rd, jsel, csel, rsel, stall, res} = '0;
    ce = 1'b1;
    {adr, wd, smpc, cidx, ridx, alt, ph_q, run, v} = '0;
    {n_fail, num_checks} = '0;
    rnd   = 32'd20;
    cbase = 24'h004000;
    rbase = 24'h002000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cbase <= {rnd[13:0], 10'h0};
    rdr(ACSQ_OFF0_ADR, 8'h00);
    rdr(ACSQ_OFF1_ADR, 8'h00);
    wrr(ACSQ_OFF0_ADR, 8'h7f);
    rdr(ACSQ_OFF0_ADR, 8'h00);
    rdr(8'h30, 8'h00);
    wrr(ACSQ_TRIG_ADR, 8'h01);
    rdr(ACSQ_STAT_ADR, 8'h00);
    $display("test reset_readonly done");
    wrr(ACSQ_OFF1_ADR, 8'h05);
    rdr(ACSQ_OFF1_ADR, 8'h05);
    wrr(ACSQ_CTRL_ADR, 8'h01);
    wrr(ACSQ_OFF1_ADR, 8'h11);
    rdr(ACSQ_OFF1_ADR, 8'h05);
    wrr(ACSQ_CTRL_ADR, 8'h03);
    wrr(ACSQ_OFF1_ADR, 8'h11);
    rdr(ACSQ_OFF1_ADR, 8'h11);
    alt = 7'h11;
    // a write while the clock enable is low leaves no trace
    @(posedge clk) ce <= 1'b0;
    wrr(ACSQ_SMPT_ADR, 8'h0b);
    @(posedge clk) ce <= 1'b1;
    rdr(ACSQ_SMPT_ADR, 8'h00);
    $display("test offset_gate done");
    // sequences end at 2, 5 and 17; lists end at 7 and 20
    for (i = 0; i < 21; i++) begin
      @(negedge clk);
      mdl.cmd[i] = {(i == 7) ? 2'h2 : (i == 20) ? 2'h3 :
                    (i % 3 == 2) ? CT_END_SEQ : CT_NORMAL, 24'h0, rnd[5:0]};
    end
    // every resolution and justification, first command list
    for (i = 0; i < 6; i++) begin
      res   = 2'(i % 3);
      jsel  = (i > 2);
      smpc  = (i == 5) ? 5'h1f : {3'h0, rnd[1:0]};
      stall = 2'h1;
      wrr(ACSQ_CTRL_ADR, {1'b0, res, jsel, 4'hd});
      rbase <= {rnd[22:0], 1'b0};
      wrr(ACSQ_SMPT_ADR, {3'h0, smpc});
      plan();
      wrr(ACSQ_TRIG_ADR, 8'h01);
      done();
    end
    $display("test first_list done");
    // second command list, then fill the result buffer
    wrr(ACSQ_TRIG_ADR, 8'h02);
    csel = 1'b1;
    plan();
    wrr(ACSQ_TRIG_ADR, 8'h01);
    done();
    e8    = {4'h0, rsel, csel, 2'h3};
    stall = 2'h2;
    plan();
    wrr(ACSQ_TRIG_ADR, 8'h01);
    for (i = 0; i < 100 && v[1] !== 1'b1; i++) rdv(ACSQ_STAT_ADR, v);
    chk_reg(v, e8);
    stall = 2'h1;
    done();
    $display("test second_list_fill done");
    // no end type in the list: it stops after index 63 and rewinds
    wrr(ACSQ_CTRL_ADR, 8'h00);
    wrr(ACSQ_OFF1_ADR, 8'h40);
    wrr(ACSQ_SMPT_ADR, 8'h00);
    wrr(ACSQ_CTRL_ADR, 8'h1d);
    wrr(ACSQ_TRIG_ADR, 8'h02);
    alt  = 7'h40;
    csel = 1'b1;
    rsel = 1'b0;
    res  = 2'h0;
    jsel = 1'b1;
    smpc = 5'h00;
    for (i = 64; i < 128; i++) begin
      mdl.cmd[i] = {CT_NORMAL, 24'h0, rnd[5:0] ^ 6'(i)};
    end
    plan();
    wrr(ACSQ_TRIG_ADR, 8'h01);
    done();
    $display("test list_bound done");
    conclude();
  end
endmodule : tb_list_based_adc_sequencer

`default_nettype wire
